// file: hw/slls_pkg.sv
/*
 * Constants for the sync lock ladder synchronizer: line geometry, window
 * bounds, ladder limits, jumper codes and the single-bit-error tables.
 * Assumes it is compiled before every file that imports it.
 */
package slls_pkg;

   // Bit-position counter geometry; a line is 975 bits long.
   localparam int          SLLS_POS_W       = 10;
   localparam logic [9:0]  SLLS_LINE_LAST   = 10'h3ce;   // 974
   localparam logic [9:0]  SLLS_POS_ZERO    = 10'h000;
   localparam logic [9:0]  SLLS_EXP_RST_END = 10'h00e;   // 14

   // Window bounds, eight, five and three bits wide.
   localparam logic [9:0]  SLLS_WIN8_START  = 10'h3cb;   // 971
   localparam logic [9:0]  SLLS_WIN8_END    = 10'h003;
   localparam logic [9:0]  SLLS_WIN6_START  = 10'h3cc;   // 972
   localparam logic [9:0]  SLLS_WIN6_END    = 10'h001;
   localparam logic [9:0]  SLLS_WIN4_START  = 10'h3cd;   // 973
   localparam logic [9:0]  SLLS_WIN4_END    = 10'h000;

   // Window jumper codes; no jumper gives the widest window.
   localparam logic [1:0]  SLLS_WINSEL_NONE = 2'h0;
   localparam logic [1:0]  SLLS_WINSEL_SIX  = 2'h1;
   localparam logic [1:0]  SLLS_WINSEL_FOUR = 2'h2;

   // Ladder option jumper codes; no jumper selects the second option.
   localparam logic [1:0]  SLLS_OPT_NONE    = 2'h0;
   localparam logic [1:0]  SLLS_OPT_FIRST   = 2'h1;
   localparam logic [1:0]  SLLS_OPT_THIRD   = 2'h2;

   // Ladder counter limits and reset values.
   localparam int          SLLS_LEVEL_W     = 3;
   localparam logic [2:0]  SLLS_LEVEL_SEARCH = 3'h0;
   localparam logic [2:0]  SLLS_LEVEL_MAX   = 3'h7;
   localparam logic [2:0]  SLLS_LEVEL_ONE   = 3'h1;
   localparam logic        SLLS_DIR_UP      = 1'h1;

   // Single-bit-error tables: bit n set means level n accepts such words,
   // one mask for a climbing ladder and one for a falling ladder.
   localparam logic [7:0]  SLLS_SBE_UP_OPT1 = 8'he0;
   localparam logic [7:0]  SLLS_SBE_DN_OPT1 = 8'hf8;
   localparam logic [7:0]  SLLS_SBE_UP_OPT2 = 8'hf0;
   localparam logic [7:0]  SLLS_SBE_DN_OPT2 = 8'hf0;
   localparam logic [7:0]  SLLS_SBE_UP_OPT3 = 8'hc0;
   localparam logic [7:0]  SLLS_SBE_DN_OPT3 = 8'hc0;

   // Synchroniser depth.
   localparam int          SLLS_SYNC_STAGES = 2;

   // Ladder activity as seen from the system side.
   typedef enum logic [1:0] {
      SLLS_SEARCHING,
      SLLS_TRACKING,
      SLLS_LOCKED
   } slls_lock_t;

endpackage : slls_pkg

// file: hw/slls_bit_sync.sv
/*
 * Two flip-flop level synchroniser, one per bit of a bus.
 * Assumes every bit is a slow level or a gray-coded value that changes
 * at most one bit at a time.
 */
`timescale 1ns/1ps
`default_nettype none

module slls_bit_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] out_d;

   // The first stage feeds only the second stage.
   always_comb begin
      meta_d = din;
      out_d  = meta_q;
   end

   // Both stages register on every rising edge.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= meta_d;
         dout   <= out_d;
      end
   end

endmodule : slls_bit_sync

`default_nettype wire

// file: hw/slls_synchronizer.sv
/*
 * Sync lock ladder synchronizer: bit-position counter, sync window,
 * confidence ladder, correlator masks, expander reset and FIFO write
 * strobe, all on the recovered bit clock, with lock status passed back
 * to the system clock.
 * Assumes the correlator works on the same bit clock, pulses its match
 * outputs for one bit period and honours both masks combinationally.
 */
`timescale 1ns/1ps
`default_nettype none

module slls_synchronizer
   import slls_pkg::*;
#(
   parameter logic [9:0] LINE_LAST = SLLS_LINE_LAST
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        bitClk,
   input  wire logic        exactSyncDetect,
   input  wire logic        single_bit_error_match,
   input  wire logic        groupCountLsb,
   input  wire logic [1:0]  ladderOptionSel,
   input  wire logic [1:0]  windowSel,
   input  wire logic        sixBitMode,
   output logic             exact_sync_mask,
   output logic             single_error_sync_mask,
   output logic             fifo_write_strobe,
   output logic             expanderReset,
   output logic [9:0]       bitPosition,
   output logic             syncLocked,
   output logic [2:0]       confidenceLevel,
   output slls_lock_t       lockState
);

   // Jumper and mode levels arrive from pins and from the system side.
   logic [4:0] cfgRaw;
   logic [4:0] cfgSync;
   logic [1:0] optSel;
   logic [1:0] winSel;
   logic       sixMode;

   assign cfgRaw = {sixBitMode, windowSel, ladderOptionSel};

   // Jumpers are static, so a plain per-bit synchroniser is enough.
   slls_bit_sync #(
      .WIDTH (5)
   ) u_cfg_sync (
      .clk   (bitClk),
      .reset (reset),
      .din   (cfgRaw),
      .dout  (cfgSync)
   );

   assign optSel  = cfgSync[1:0];
   assign winSel  = cfgSync[3:2];
   assign sixMode = cfgSync[4];

   // Looks up whether single-bit-error words are taken at this level.
   function automatic logic sbeAllowed(input logic [1:0] opt,
                                       input logic [2:0] lvl,
                                       input logic       up);
      logic [7:0] tbl;
      tbl = 8'h00;
      case (opt)
         SLLS_OPT_FIRST: tbl = up ? SLLS_SBE_UP_OPT1 : SLLS_SBE_DN_OPT1;
         SLLS_OPT_THIRD: tbl = up ? SLLS_SBE_UP_OPT3 : SLLS_SBE_DN_OPT3;
         default:        tbl = up ? SLLS_SBE_UP_OPT2 : SLLS_SBE_DN_OPT2;
      endcase
      return tbl[lvl];
   endfunction : sbeAllowed

   // Bit-clock state.
   logic [9:0] pos_q;
   logic [9:0] pos_d;
   logic [2:0] level_q;
   logic [2:0] level_d;
   logic       lastUp_q;
   logic       lastUp_d;
   logic       seen_q;
   logic       seen_d;
   logic       lsbPrev_q;
   logic       lsbPrev_d;
   logic       phase_q;
   logic       phase_d;
   logic       strobe_q;
   logic       strobe_d;
   logic       expRst_q;
   logic       expRst_d;
   logic [2:0] gray_q;
   logic [2:0] gray_d;

   // Window decode and mask terms.
   logic [9:0] winStart;
   logic [9:0] winEnd;
   logic       winOpen;
   logic       atWinEnd;
   logic       searching;
   logic       sbeOk;
   logic       accepted;
   logic       groupRise;

   // Window bounds follow the window jumper.
   always_comb begin
      case (winSel)
         SLLS_WINSEL_SIX: begin
            winStart = SLLS_WIN6_START;
            winEnd   = SLLS_WIN6_END;
         end
         SLLS_WINSEL_FOUR: begin
            winStart = SLLS_WIN4_START;
            winEnd   = SLLS_WIN4_END;
         end
         default: begin
            winStart = SLLS_WIN8_START;
            winEnd   = SLLS_WIN8_END;
         end
      endcase
   end

   // The window wraps through zero, so it is the union of two ranges.
   // Once a sync has been taken the rest of the window stays shut, which
   // keeps a false word just behind a true one from counting twice.
   assign searching = (level_q == SLLS_LEVEL_SEARCH);
   assign winOpen   = ((pos_q >= winStart) || (pos_q <= winEnd)) && !seen_q;
   assign atWinEnd  = (pos_q == winEnd);
   assign sbeOk     = sbeAllowed(optSel, level_q, lastUp_q);

   // Masks go straight to the correlator within the same bit period.
   assign exact_sync_mask        = !searching && !winOpen;
   assign single_error_sync_mask = !sbeOk || exact_sync_mask;

   // Matches are gated here too, so a late mask never leaks a word.
   assign accepted = (exactSyncDetect && !exact_sync_mask) ||
                     (single_bit_error_match && !single_error_sync_mask);
   assign groupRise = groupCountLsb && !lsbPrev_q;

   // Position counter, restarted by an accepted word or at line end.
   always_comb begin
      if (accepted || (pos_q == LINE_LAST)) begin
         pos_d = SLLS_POS_ZERO;
      end else begin
         pos_d = pos_q + 10'h001;
      end
   end

   // Ladder movement: one step per window, never past either end.
   always_comb begin
      level_d  = level_q;
      lastUp_d = lastUp_q;
      seen_d   = seen_q;
      if (searching) begin
         if (accepted) begin
            level_d  = SLLS_LEVEL_ONE;
            lastUp_d = SLLS_DIR_UP;
            seen_d   = 1'b1;
         end
      end else if (accepted) begin
         if (level_q != SLLS_LEVEL_MAX) begin
            level_d = level_q + SLLS_LEVEL_ONE;
         end
         lastUp_d = SLLS_DIR_UP;
         seen_d   = 1'b1;
      end else if (atWinEnd && !seen_q) begin
         // A miss on the first step lands back in search.
         level_d  = level_q - SLLS_LEVEL_ONE;
         lastUp_d = !SLLS_DIR_UP;
      end
      // The window closes after its last position. A word taken on that
      // very position keeps it shut, or the line restart at zero would
      // reopen the window and let a second word count in the same slot.
      if (atWinEnd && !searching && !accepted) begin
         seen_d = 1'b0;
      end
      if (level_d == SLLS_LEVEL_SEARCH) begin
         seen_d = 1'b0;
      end
   end

   // Strobe timing and expander reset. The low group-counter bit rises
   // once per three-bit group, a cycle after the expander latch, so the
   // lookup memory has settled before the FIFO takes the value.
   always_comb begin
      lsbPrev_d = groupCountLsb;
      expRst_d  = (pos_d <= SLLS_EXP_RST_END);
      phase_d   = phase_q;
      strobe_d  = 1'b0;
      if (expRst_d) begin
         // Pair alignment restarts with each line.
         phase_d = 1'b0;
      end else if (groupRise) begin
         strobe_d = !sixMode || phase_q;
         phase_d  = sixMode && !phase_q;
      end
      gray_d = level_d ^ (level_d >> 1);
   end

   // Bit-clock registers; reset puts the ladder into search.
   always_ff @(posedge bitClk or posedge reset) begin
      if (reset) begin
         pos_q     <= SLLS_POS_ZERO;
         level_q   <= SLLS_LEVEL_SEARCH;
         lastUp_q  <= SLLS_DIR_UP;
         seen_q    <= 1'b0;
         lsbPrev_q <= 1'b0;
         phase_q   <= 1'b0;
         strobe_q  <= 1'b0;
         expRst_q  <= 1'b1;
         gray_q    <= 3'h0;
      end else begin
         pos_q     <= pos_d;
         level_q   <= level_d;
         lastUp_q  <= lastUp_d;
         seen_q    <= seen_d;
         lsbPrev_q <= lsbPrev_d;
         phase_q   <= phase_d;
         strobe_q  <= strobe_d;
         expRst_q  <= expRst_d;
         gray_q    <= gray_d;
      end
   end

   assign fifo_write_strobe = strobe_q;
   assign expanderReset     = expRst_q;
   assign bitPosition       = pos_q;

   // Status crossing: the ladder moves one step at a time, so its gray
   // code changes in one bit and can be synchronised bit by bit.
   logic [2:0] graySync;
   logic [2:0] levelBin;
   logic [2:0] conf_q;
   logic [2:0] conf_d;
   logic       locked_q;
   logic       locked_d;
   slls_lock_t state_q;
   slls_lock_t state_d;

   slls_bit_sync #(
      .WIDTH (3)
   ) u_level_sync (
      .clk   (clk),
      .reset (reset),
      .din   (gray_q),
      .dout  (graySync)
   );

   // Gray back to binary, then the lock summary.
   always_comb begin
      levelBin[2] = graySync[2];
      levelBin[1] = graySync[2] ^ graySync[1];
      levelBin[0] = graySync[2] ^ graySync[1] ^ graySync[0];
      conf_d      = levelBin;
      locked_d    = (levelBin == SLLS_LEVEL_MAX);
      case (levelBin)
         SLLS_LEVEL_SEARCH: state_d = SLLS_SEARCHING;
         SLLS_LEVEL_MAX:    state_d = SLLS_LOCKED;
         default:           state_d = SLLS_TRACKING;
      endcase
   end

   // System-clock status registers.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         conf_q   <= SLLS_LEVEL_SEARCH;
         locked_q <= 1'b0;
         state_q  <= SLLS_SEARCHING;
      end else begin
         conf_q   <= conf_d;
         locked_q <= locked_d;
         state_q  <= state_d;
      end
   end

   assign confidenceLevel = conf_q;
   assign syncLocked      = locked_q;
   assign lockState       = state_q;

endmodule : slls_synchronizer

`default_nettype wire

// file: tb/slls_synchronizer_properties.sv
/* Concurrent checks on the synchronizer ports, both clock domains.
 * Assumes the correlator pulses its match inputs for one bit period. */
`timescale 1ns/1ps
`default_nettype none
module slls_synchronizer_props
   import slls_pkg::*;
#(
   parameter logic [9:0] LINE_LAST = SLLS_LINE_LAST
) (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       bitClk,
   input wire logic       exactSyncDetect,
   input wire logic       single_bit_error_match,
   input wire logic       groupCountLsb,
   input wire logic [1:0] ladderOptionSel,
   input wire logic [1:0] windowSel,
   input wire logic       sixBitMode,
   input wire logic       exact_sync_mask,
   input wire logic       single_error_sync_mask,
   input wire logic       fifo_write_strobe,
   input wire logic       expanderReset,
   input wire logic [9:0] bitPosition,
   input wire logic       syncLocked,
   input wire logic [2:0] confidenceLevel,
   input wire slls_lock_t lockState
);
   // A word counts only when its own mask lets it through.
   wire logic taken = (exactSyncDetect & ~exact_sync_mask) |
                      (single_bit_error_match & ~single_error_sync_mask);

   sequence s_lsb_rise;
      !groupCountLsb ##1 groupCountLsb;
   endsequence

   // Line counter, masks and strobe, all judged on the bit clock.
   a_pos_wrap: assert property (
      @(posedge bitClk) disable iff (reset) bitPosition == LINE_LAST |=>
      bitPosition == 10'h000) else $error("position did not wrap");
   a_pos_count: assert property (
      @(posedge bitClk) disable iff (reset) !taken && bitPosition != LINE_LAST
      |=> bitPosition == $past(bitPosition) + 10'h001) else $error("no step");
   a_sync_restart: assert property (
      @(posedge bitClk) disable iff (reset) taken |=> bitPosition == 10'h000)
      else $error("sync did not restart the line");
   a_window_shut: assert property (
      @(posedge bitClk) disable iff (reset) taken |=> exact_sync_mask)
      else $error("window left open after a taken word");
   a_search_single: assert property (
      @(posedge bitClk) disable iff (reset) !exact_sync_mask &&
      bitPosition inside {[10'h004:10'h3ca]} |-> single_error_sync_mask)
      else $error("single-error word open outside window");
   a_single_covers: assert property (
      @(posedge bitClk) disable iff (reset)
      exact_sync_mask |-> single_error_sync_mask) else $error("mask order");
   a_exp_span: assert property (
      @(posedge bitClk) disable iff (reset)
      expanderReset == (bitPosition <= 10'h00e)) else $error("expander reset");
   a_strobe_cause: assert property (
      @(posedge bitClk) disable iff (reset) fifo_write_strobe |-> !expanderReset
      && $past(groupCountLsb) && !$past(groupCountLsb, 2))
      else $error("strobe without a group rise");
   a_strobe_first: assert property (
      @(posedge bitClk) disable iff (reset) (s_lsb_rise ##0
      (bitPosition == 10'h010 && !sixBitMode)) |=> fifo_write_strobe)
      else $error("first write of the line missing");

   // The status copy moves one rung at a time.
   a_level_step: assert property (
      @(posedge clk) disable iff (reset) $changed(confidenceLevel) |->
      3'(confidenceLevel - $past(confidenceLevel)) inside {3'h1, 3'h7})
      else $error("level jumped");
endmodule : slls_synchronizer_props

bind slls_synchronizer slls_synchronizer_props #(.LINE_LAST(LINE_LAST)) u_props (
   .clk, .reset, .bitClk, .exactSyncDetect, .single_bit_error_match,
   .groupCountLsb, .ladderOptionSel, .windowSel, .sixBitMode,
   .exact_sync_mask, .single_error_sync_mask, .fifo_write_strobe,
   .expanderReset, .bitPosition, .syncLocked, .confidenceLevel, .lockState);
`default_nettype wire

// file: tb/slls_correlator_model.sv
/* Correlator stand-in: sync pulses at a chosen position, group count lsb.
 * Assumes the bench sets the fire controls well before the position. */
`timescale 1ns/1ps
`default_nettype none
module slls_correlator_model (
   input  wire logic       bitClk,
   input  wire logic       reset,
   input  wire logic [9:0] bitPosition,
   input  wire logic       fireExact,
   input  wire logic       fireSbe,
   input  wire logic [9:0] firePos,
   output logic            exactSyncDetect,
   output logic            single_bit_error_match,
   output logic            groupCountLsb
);
   // Falling-edge drive gives the design half a period of setup.
   // Matches are raised whatever the masks say; blocking is the design's job.
   always_ff @(negedge bitClk or posedge reset) begin
      if (reset) begin
         exactSyncDetect        <= 1'b0;
         single_bit_error_match <= 1'b0;
         groupCountLsb          <= 1'b0;
      end else begin
         exactSyncDetect        <= fireExact && (bitPosition == firePos);
         single_bit_error_match <= fireSbe && (bitPosition == firePos);
         groupCountLsb <= (bitPosition % 10'h003) == 10'h001;
      end
   end
endmodule : slls_correlator_model
`default_nettype wire

// file: tb/slls_synchronizer_test.sv
/* Ladder, window and strobe scenarios for the synchronizer.
 * Assumes the correlator model and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module slls_synchronizer_test;
   import slls_pkg::*;
   logic       clk = 1'b0;
   logic       bitClk = 1'b0;
   logic       reset = 1'b1;
   logic [1:0] ladderOptionSel = 2'h0;
   logic [1:0] windowSel = 2'h0;
   logic       sixBitMode = 1'b0;
   logic       fireExact = 1'b0;
   logic       fireSbe = 1'b0;
   logic [9:0] firePos = 10'h000;
   logic       exactSyncDetect, single_bit_error_match, groupCountLsb;
   logic       exact_sync_mask, single_error_sync_mask, fifo_write_strobe;
   logic       expanderReset, syncLocked;
   logic [9:0] bitPosition;
   logic [2:0] confidenceLevel;
   slls_lock_t lockState;
   int         n_fail = 0;
   int         n_tests = 0;
   int         cycles = 0;
   int         i;

   // Two unrelated clocks; the bit clock starts off phase.
   initial forever #10 clk = ~clk;
   initial begin
      #7;
      forever #15 bitClk = ~bitClk;
   end

   slls_synchronizer uut (.clk, .reset, .bitClk, .exactSyncDetect,
      .single_bit_error_match, .groupCountLsb, .ladderOptionSel, .windowSel,
      .sixBitMode, .exact_sync_mask, .single_error_sync_mask,
      .fifo_write_strobe, .expanderReset, .bitPosition, .syncLocked,
      .confidenceLevel, .lockState);
   slls_correlator_model peer (.bitClk, .reset, .bitPosition, .fireExact,
      .fireSbe, .firePos, .exactSyncDetect, .single_bit_error_match,
      .groupCountLsb);

   task automatic finish_test();
      if (n_fail == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Bounded so a stuck counter ends in the watchdog, not a hang here.
   task automatic wait_pos(input logic [9:0] p);
      for (int k = 0; k < 2000 && bitPosition !== p; k++) @(negedge bitClk);
   endtask : wait_pos

   // One line: offer a word at pos, let the window end, read the level.
   task automatic step(input logic [1:0] opt, input logic [1:0] win,
                       input logic ex, input logic sb,
                       input logic [9:0] pos, input logic [2:0] lvl);
      @(negedge clk);
      ladderOptionSel = opt;
      windowSel = win;
      fireExact = ex;
      fireSbe = sb;
      firePos = pos;
      wait_pos(pos);
      wait_pos(10'h00a);
      @(negedge clk);
      fireExact = 1'b0;
      fireSbe = 1'b0;
      repeat (8) @(negedge clk);
      chk({7'h00, confidenceLevel}, {7'h00, lvl});
   endtask : step

   // Counts FIFO writes over one whole line in the given pixel mode.
   task automatic count_line(input logic six, input logic [9:0] exp);
      logic [9:0] n;
      wait_pos(10'h1f4);
      @(negedge clk);
      sixBitMode = six;
      wait_pos(10'h000);
      n = 10'h000;
      do begin
         @(negedge bitClk);
         if (fifo_write_strobe === 1'b1) n = n + 10'h001;
      end while (bitPosition !== 10'h000);
      chk(n, exp);
   endtask : count_line

   // Watchdog sized for about 61 lines of 975 bits.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         n_fail++;
         finish_test();
      end
   end

   // Main sequence: reset state, climb, descent, windows, options, strobes.
   initial begin
      repeat (3) @(negedge clk);
      chk({7'h00, exact_sync_mask, single_error_sync_mask, expanderReset},
          10'h003);
      chk(bitPosition | {7'h00, confidenceLevel}, 10'h000);
      reset = 1'b0;
      step(2'h0, 2'h0, 1'b1, 1'b0, 10'h1f4, 3'h1);
      step(2'h0, 2'h0, 1'b0, 1'b1, 10'h3ce, 3'h0);
      step(2'h0, 2'h0, 1'b0, 1'b1, 10'h1f4, 3'h0);
      step(2'h0, 2'h0, 1'b1, 1'b0, 10'h1f4, 3'h1);
      for (i = 2; i <= 7; i++)
         step(2'h0, 2'h0, 1'b1, 1'b0, 10'h3ce, 3'(i));
      step(2'h0, 2'h0, 1'b1, 1'b0, 10'h3ce, 3'h7);
      chk({8'h00, syncLocked, 1'b0}, 10'h002);
      chk({8'h00, lockState}, {8'h00, SLLS_LOCKED});
      step(2'h0, 2'h0, 1'b0, 1'b1, 10'h3ce, 3'h7);
      for (i = 6; i >= 4; i--)
         step(2'h0, 2'h0, 1'b0, 1'b0, 10'h000, 3'(i));
      step(2'h0, 2'h0, 1'b0, 1'b1, 10'h002, 3'h5);
      for (i = 4; i >= 3; i--)
         step(2'h0, 2'h0, 1'b0, 1'b0, 10'h000, 3'(i));
      step(2'h0, 2'h0, 1'b0, 1'b1, 10'h3ce, 3'h2);
      for (i = 1; i >= 0; i--)
         step(2'h0, 2'h0, 1'b0, 1'b0, 10'h000, 3'(i));
      step(2'h0, 2'h0, 1'b0, 1'b0, 10'h000, 3'h0);
      chk({8'h00, lockState}, {8'h00, SLLS_SEARCHING});
      step(2'h0, 2'h2, 1'b1, 1'b0, 10'h1f4, 3'h1);
      step(2'h0, 2'h2, 1'b1, 1'b0, 10'h3cc, 3'h0);
      step(2'h0, 2'h1, 1'b1, 1'b0, 10'h1f4, 3'h1);
      step(2'h0, 2'h1, 1'b1, 1'b0, 10'h3cc, 3'h2);
      step(2'h0, 2'h1, 1'b1, 1'b0, 10'h3cb, 3'h1);
      step(2'h0, 2'h0, 1'b1, 1'b0, 10'h3cb, 3'h2);
      step(2'h1, 2'h0, 1'b1, 1'b0, 10'h3ce, 3'h3);
      step(2'h1, 2'h0, 1'b1, 1'b0, 10'h3ce, 3'h4);
      step(2'h1, 2'h0, 1'b0, 1'b1, 10'h3ce, 3'h3);
      step(2'h1, 2'h0, 1'b0, 1'b1, 10'h3ce, 3'h4);
      step(2'h1, 2'h0, 1'b0, 1'b1, 10'h3ce, 3'h3);
      step(2'h2, 2'h0, 1'b1, 1'b0, 10'h3ce, 3'h4);
      step(2'h2, 2'h0, 1'b1, 1'b0, 10'h3ce, 3'h5);
      step(2'h2, 2'h0, 1'b0, 1'b1, 10'h3ce, 3'h4);
      step(2'h3, 2'h0, 1'b0, 1'b1, 10'h3ce, 3'h5);
      count_line(1'b1, 10'h0a0);
      count_line(1'b0, 10'h140);
      finish_test();
   end
endmodule : slls_synchronizer_test
`default_nettype wire
